// *** verilog/ac_pkg.sv ***
`default_nettype none
package ac_pkg;

    // ------------------------------------------------------------
    // register select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_CONTROL  = 2'h0;
    localparam logic [1:0] SEL_TAG      = 2'h1;
    localparam logic [1:0] SEL_POLARITY = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_VERSION_BIT = 31;
    localparam int CTL_RX_DMA_BIT  = 22;
    localparam int CTL_TX_DMA_BIT  = 21;
    localparam int CTL_FLUSH_HI    = 20;
    localparam int TAG_READY_BIT   = 31;
    localparam int TAG_RXV_HI      = 30;
    localparam int TAG_RXV_LO      = 19;
    localparam int TAG_TXV_HI      = 12;
    localparam int TAG_TXV_LO      = 3;
    localparam int POL_HI          = 12;
    localparam int POL_LO          = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
    localparam logic [31:0] TAG_RESET      = 32'h0000_0000;
    localparam logic [15:0] POLARITY_RESET = 16'h0000;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam logic [3:0] LAST_SLOT     = 4'hc;
    localparam logic [4:0] TAG_SLOT_LAST = 5'hf;
    localparam logic [4:0] DATA_SLOT_LAST = 5'h13;
    localparam logic [3:0] SLOT_CMD      = 4'h1;
    localparam logic [3:0] SLOT_LEFT     = 4'h3;
    localparam logic [3:0] SLOT_RIGHT    = 4'h4;
    localparam int         SAMPLE_WIDTH  = 20;
    localparam int         PCM_DEPTH     = 32;

endpackage : ac_pkg
`default_nettype wire

// *** verilog/ac_ctrl_tag.sv ***
// Behaviour
// - control register is write-only, reset to zero, bits 30..23 unused.
// - control bit 31 selects version 2.0 when one, else 1.03.
// - bit 22 enables receive DMA while set.
// - bit 21 enables transmit DMA while set.
// - with any DMA enabled, left and right PCM share the left path, interleaved.
// - bits 20..17 flush command address, command data, status address, status data.
// - bits 16..7 flush the ten transmit FIFOs in listed order.
// - bits 6..0 flush the seven receive FIFOs in listed order.
// - tag register writes transmit tags, reads receive tags in 31..19 and written transmit flags in 12..3; 18..13 read zero.
// - tag bit 31 shows codec ready from the received tag.
// - tag bits 30..19 show received valid flags of slots 1..12.
// - polarity register is 16 bits read/write; 15..13 and 2..0 read zero.
// - polarity bit n one means slot n request active high, else low.
// - version 1.03 sends tag register valid bits for slots 3..12.
// - version 2.0 uses received slot requests as next frame valid flags.
// - frame valid clear only if all slot flags clear; slots 1,2 follow command FIFOs.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// sample FIFO
// ----------------------------------------------------------------
module ac_fifo
    import ac_pkg::*;
#(
    parameter int WIDTH = SAMPLE_WIDTH,
    parameter int DEPTH = PCM_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] count;
    } ac_fifo_t;

    ac_fifo_t         s;
    ac_fifo_t         next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // handshakes straight from the occupancy count
    assign inReady  = (s.count != CW'(DEPTH));
    assign outValid = (s.count != '0);
    assign outData  = mem[s.rp];
    assign push     = inValid & inReady & ~flush;
    assign pop      = outValid & outReady & ~flush;

    // pointer update; flush wins over push and pop
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = s.rp + AW'(1);
        end
        next_s.count = s.count + CW'(push) - CW'(pop);
        if (flush) begin
            next_s = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // storage carries no reset, only the pointers matter
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[s.wp] <= inData;
        end
    end
endmodule : ac_fifo

// ----------------------------------------------------------------
// control, tag and slot request logic
// ----------------------------------------------------------------
module ac_ctrl_tag
    import ac_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [1:0]  regSel,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        pcmWrValid,
    output logic             pcmWrReady,
    input  wire logic [19:0] pcmWrData,
    input  wire logic        cmdAddrPending,
    input  wire logic        cmdDataPending,
    input  wire logic        bitClk,
    input  wire logic        sdataIn,
    output logic             sdataOut,
    output logic             syncOut,
    output logic             version20,
    output logic             rxDmaEnable,
    output logic             txDmaEnable,
    output logic             pcmInterleave,
    output logic      [20:0] flushPulse
);
    typedef struct packed {
        logic        version20;
        logic        rxDma;
        logic        txDma;
        logic [20:0] flush;
        logic [9:0]  txValid;
        logic [9:0]  pol;
        logic        ready;
        logic [11:0] rxValid;
        logic [9:0]  slot_request_capture;
        logic [31:0] rdata;
        logic [1:0]  clkSync;
        logic        clkPrev;
        logic [1:0]  dinSync;
        logic [3:0]  txSlot;
        logic [4:0]  txBit;
        logic [19:0] txShift;
        logic        dout;
        logic        sync;
        logic [3:0]  rxSlot;
        logic [4:0]  rxBit;
        logic [19:0] rxShift;
    } ac_state_t;

    ac_state_t   s;
    ac_state_t   next_s;
    logic        rise;
    logic        fall;
    logic        popFifo;
    logic        fifoValid;
    logic [19:0] fifoData;
    logic [19:0] word;
    logic [19:0] rxWord;
    logic [9:0]  slotValid;
    logic [15:0] tagOut;

    // last bit index of a slot: tag slot is 16 bits, data slots 20
    function automatic logic [4:0] slotLast(input logic [3:0] slot);
        slotLast = (slot == 4'h0) ? TAG_SLOT_LAST : DATA_SLOT_LAST;
    endfunction : slotLast

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdata      = s.rdata;
    assign sdataOut      = s.dout;
    assign syncOut       = s.sync;
    assign version20     = s.version20;
    assign rxDmaEnable   = s.rxDma;
    assign txDmaEnable   = s.txDma;
    assign pcmInterleave = s.rxDma | s.txDma;
    assign flushPulse    = s.flush;

    // link clock edges seen only after the two-stage synchroniser
    assign rise = s.clkSync[1] & ~s.clkPrev;
    assign fall = ~s.clkSync[1] & s.clkPrev;

    // slot flag source depends on protocol version; requests of one frame feed the next tag
    assign slotValid = s.version20 ? s.slot_request_capture : s.txValid;
    assign tagOut    = {|{cmdAddrPending, cmdDataPending, slotValid},
                        cmdAddrPending, cmdDataPending, slotValid, 3'h0};
    assign rxWord    = {s.rxShift[18:0], s.dinSync[1]};

    // pcm samples: both slots drain one FIFO when interleaved
    ac_fifo #(
        .WIDTH (SAMPLE_WIDTH),
        .DEPTH (PCM_DEPTH)
    ) u_pcm_fifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .flush    (s.flush[16] | s.flush[15]),
        .inValid  (pcmWrValid),
        .inReady  (pcmWrReady),
        .inData   (pcmWrData),
        .outValid (fifoValid),
        .outReady (popFifo),
        .outData  (fifoData)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s          = s;
        popFifo         = 1'b0;
        word            = '0;
        next_s.clkSync  = {s.clkSync[0], bitClk};
        next_s.clkPrev  = s.clkSync[1];
        next_s.dinSync  = {s.dinSync[0], sdataIn};
        next_s.flush    = '0;
        next_s.rdata    = '0;
        // register writes
        if (regWr) begin
            case (regSel)
                SEL_CONTROL: begin
                    next_s.version20 = regWdata[CTL_VERSION_BIT];
                    next_s.rxDma     = regWdata[CTL_RX_DMA_BIT];
                    next_s.txDma     = regWdata[CTL_TX_DMA_BIT];
                    next_s.flush     = regWdata[CTL_FLUSH_HI:0];
                end
                SEL_TAG:      next_s.txValid = regWdata[TAG_TXV_HI:TAG_TXV_LO];
                SEL_POLARITY: next_s.pol = regWdata[POL_HI:POL_LO];
                default: ;
            endcase
        end
        // register reads; control reads back as zero
        if (regRd) begin
            case (regSel)
                SEL_TAG: next_s.rdata = {s.ready, s.rxValid, 6'h0,
                                         s.txValid, 3'h0};
                SEL_POLARITY: next_s.rdata = {19'h0, s.pol, 3'h0};
                default: next_s.rdata = '0;
            endcase
        end
        // transmit side, launched on link clock rising edges
        if (rise) begin
            if (s.txBit == 5'h0) begin
                case (s.txSlot)
                    4'h0: word = {tagOut, 4'h0};
                    SLOT_LEFT: begin
                        popFifo = fifoValid;
                        word    = fifoValid ? fifoData : '0;
                    end
                    SLOT_RIGHT: begin
                        popFifo = fifoValid & (s.rxDma | s.txDma);
                        word    = popFifo ? fifoData : '0;
                    end
                    default: word = '0;
                endcase
                next_s.dout    = word[19];
                next_s.txShift = {word[18:0], 1'b0};
            end else begin
                next_s.dout    = s.txShift[19];
                next_s.txShift = {s.txShift[18:0], 1'b0};
            end
            next_s.sync = (s.txSlot == 4'h0);
            if (s.txBit == slotLast(s.txSlot)) begin
                next_s.txBit  = '0;
                next_s.txSlot = (s.txSlot == LAST_SLOT) ? '0 : s.txSlot + 4'h1;
            end else begin
                next_s.txBit = s.txBit + 5'h1;
            end
        end
        // receive side, sampled on link clock falling edges
        if (fall) begin
            next_s.rxShift = rxWord;
            if (s.rxBit == slotLast(s.rxSlot)) begin
                next_s.rxBit  = '0;
                next_s.rxSlot = (s.rxSlot == LAST_SLOT) ? '0 : s.rxSlot + 4'h1;
                if (s.rxSlot == 4'h0) begin
                    next_s.ready   = rxWord[15];
                    next_s.rxValid = rxWord[14:3];
                end
                if (s.rxSlot == SLOT_CMD && s.version20) begin
                    for (int j = 0; j < 10; j++) begin
                        next_s.slot_request_capture[j] = ~(rxWord[2+j] ^ s.pol[9-j]);
                    end
                end
            end else begin
                next_s.rxBit = s.rxBit + 5'h1;
            end
        end
    end

    // state register; only a hardware reset clears it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    flush_strobe_a: assert property (
        regWr && regSel == SEL_CONTROL |=> flushPulse == $past(regWdata[20:0]))
        else $error("flush strobes do not follow control write");

    flush_oneshot_a: assert property (
        flushPulse != '0 && !(regWr && regSel == SEL_CONTROL) |=> flushPulse == '0)
        else $error("flush strobe lasted more than one cycle");

    version_sel_a: assert property (
        regWr && regSel == SEL_CONTROL |=> version20 == $past(regWdata[31]))
        else $error("version select not taken");

    dma_enable_a: assert property (
        regWr && regSel == SEL_CONTROL |=> rxDmaEnable == $past(regWdata[22])
            && txDmaEnable == $past(regWdata[21]))
        else $error("dma enable not taken");

    ctl_readzero_a: assert property (
        regRd && regSel == SEL_CONTROL |=> regRdata == '0)
        else $error("control register read non-zero");

    tag_reserved_a: assert property (
        regRd && regSel == SEL_TAG |=> regRdata[18:13] == '0 && regRdata[2:0] == '0)
        else $error("tag reserved bits read non-zero");

    pol_reserved_a: assert property (
        regRd && regSel == SEL_POLARITY |=> regRdata[31:13] == '0 && regRdata[2:0] == '0)
        else $error("polarity reserved bits read non-zero");

    right_slot_a: assert property (
        rise && s.txBit == 5'h0 && s.txSlot == SLOT_RIGHT && !pcmInterleave
            |-> !popFifo)
        else $error("right slot drained without interleave");
endmodule : ac_ctrl_tag
`default_nettype wire

// *** tb/ac_codec_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// codec stand-in: free bit clock, locks to the frame sync
// ------------------------------------------------------------
module ac_codec_model (
    output logic             bitClk,
    output logic             sdataIn,
    input  wire logic        sdataOut,
    input  wire logic        syncOut,
    input  wire logic [11:0] rxValid,
    input  wire logic [9:0]  slot_request_capture,
    output logic      [15:0] txTag,
    output logic      [19:0] txSlot3,
    output logic      [19:0] txSlot4,
    output logic      [7:0]  frames
);
    logic [7:0]  idx;
    logic [7:0]  nxt;
    logic        prevSync;
    logic [95:0] sh;
    logic [35:0] rxFrame;
    // ready flag, slot flags, then slot 1 carrying the requests
    assign rxFrame = {1'b1, rxValid, 3'h0, 8'h0, slot_request_capture, 2'h0};
    assign nxt = idx + 8'h1;
    initial begin
        bitClk = 1'b0;
        sdataIn = 1'b0;
        idx = 8'hff;
        prevSync = 1'b0;
        sh = 96'h0;
        txTag = 16'h0;
        txSlot3 = 20'h0;
        txSlot4 = 20'h0;
        frames = 8'h0;
        forever #80 bitClk = ~bitClk;
    end
    // launch on rising so the bit is settled at the falling sample
    always @(posedge bitClk) begin
        sdataIn <= (nxt < 8'd36) ? rxFrame[8'd35 - nxt] : nxt[0];
    end
    // rise of sync marks bit 0; tag, slot 3 and slot 4 kept once slot 4 is in
    always @(negedge bitClk) begin
        idx = (syncOut && !prevSync) ? 8'h0 : nxt;
        prevSync = syncOut;
        sh = {sh[94:0], sdataOut};
        if (idx == 8'd95) begin
            txTag = sh[95:80];
            txSlot3 = sh[39:20];
            txSlot4 = sh[19:0];
            frames = frames + 8'h1;
        end
    end
endmodule : ac_codec_model
`default_nettype wire

// *** tb/tb_ac_ctrl_tag.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ac_ctrl_tag
    import ac_pkg::*;
;
    logic        sysClk, arstN, regWr, regRd, pcmWrValid, pcmWrReady;
    logic        cmdAddrPending, cmdDataPending, bitClk, sdataIn, sdataOut, syncOut;
    logic        version20, rxDmaEnable, txDmaEnable, pcmInterleave;
    logic [1:0]  regSel;
    logic [31:0] regWdata, regRdata;
    logic [19:0] pcmWrData, txSlot3, txSlot4;
    logic [20:0] flushPulse;
    logic [11:0] rxValid;
    logic [9:0]  slot_request_capture;
    logic [15:0] txTag;
    logic [7:0]  frames;
    int          nErrors, samplesChecked;

    ac_ctrl_tag ac_ctrl_tag_inst (
        .sys_clk(sysClk), .arst_n(arstN), .regWr(regWr), .regRd(regRd), .regSel(regSel),
        .regWdata(regWdata), .regRdata(regRdata), .pcmWrValid(pcmWrValid),
        .pcmWrReady(pcmWrReady), .pcmWrData(pcmWrData), .cmdAddrPending(cmdAddrPending),
        .cmdDataPending(cmdDataPending), .bitClk(bitClk), .sdataIn(sdataIn),
        .sdataOut(sdataOut), .syncOut(syncOut), .version20(version20),
        .rxDmaEnable(rxDmaEnable), .txDmaEnable(txDmaEnable),
        .pcmInterleave(pcmInterleave), .flushPulse(flushPulse)
    );
    ac_codec_model ac_codec_model_inst (
        .bitClk(bitClk), .sdataIn(sdataIn), .sdataOut(sdataOut), .syncOut(syncOut),
        .rxValid(rxValid), .slot_request_capture(slot_request_capture), .txTag(txTag), .txSlot3(txSlot3),
        .txSlot4(txSlot4), .frames(frames)
    );
    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        sysClk = 1'b0;
        forever #2.5 sysClk = ~sysClk;
    end
    task automatic print_verdict;
        if (nErrors == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // strobe held over exactly one taking edge; outputs read 1 ns later
    task automatic wr(input logic [1:0] sel, input logic [31:0] data);
        @(posedge sysClk);
        regWr <= 1'b1;
        regSel <= sel;
        regWdata <= data;
        @(posedge sysClk);
        regWr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdChk(input logic [1:0] sel, input logic [31:0] exp, input string what);
        @(posedge sysClk);
        regRd <= 1'b1;
        regSel <= sel;
        @(posedge sysClk);
        regRd <= 1'b0;
        #1;
        chk(what, exp, regRdata);
    endtask : rdChk
    // ends just after the codec has taken tag, slot 3 and slot 4 of a frame
    task automatic waitFrames(input int n);
        logic [7:0] target;
        int         c;
        target = frames + 8'(n);
        c = 0;
        while (frames !== target) begin
            @(posedge sysClk);
            c++;
            if (c > 9000 * n) begin
                chk("frame count", {24'h0, target}, {24'h0, frames});
                print_verdict();
            end
        end
    endtask : waitFrames
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdChk(SEL_TAG, 32'h0, "tag reset");
        rdChk(SEL_POLARITY, 32'h0, "polarity reset");
        for (int j = 0; j < 3; j++) begin
            wr(SEL_CONTROL, 32'h8000_0000 >> (j == 0 ? 0 : j + 8));
            chk("enables", {29'h0, 3'b100 >> j}, {29'h0, version20, rxDmaEnable, txDmaEnable});
            chk("pcmInterleave", {31'h0, j != 0}, {31'h0, pcmInterleave});
        end
        // reserved bits only: all enables must read zero and no flush may pulse
        wr(SEL_CONTROL, 32'h7f80_0000);
        chk("enables", 32'h0, {29'h0, version20, rxDmaEnable, txDmaEnable});
        chk("flushPulse", 32'h0, {11'h0, flushPulse});
        rdChk(SEL_CONTROL, 32'h0, "control read");
        for (int i = 0; i < 21; i++) begin
            wr(SEL_CONTROL, 32'h1 << i);
            chk("flushPulse", 32'h1 << i, {11'h0, flushPulse});
            @(posedge sysClk);
            #1;
            chk("flushPulse", 32'h0, {11'h0, flushPulse});
        end
        wr(SEL_POLARITY, 32'hffff_ffff);
        rdChk(SEL_POLARITY, 32'h0000_1ff8, "polarity");
        wr(2'h3, 32'hffff_ffff);
        rdChk(2'h3, 32'h0, "unmapped");
    endtask : t_regs
    task automatic t_link;
        waitFrames(1);
        chk("txTag idle", 32'h0, {16'h0, txTag});
        rdChk(SEL_TAG, {1'b1, 12'ha5c, 19'h0}, "rx tag");
        // upper bits written as ones must not stick; low three kept zero
        wr(SEL_TAG, {19'h7ffff, 10'h301, 3'h0});
        @(posedge sysClk);
        cmdAddrPending <= 1'b1;
        waitFrames(1);
        chk("txTag v1", {16'h0, 3'b110, 10'h301, 3'h0}, {16'h0, txTag});
        rdChk(SEL_TAG, {1'b1, 12'ha5c, 6'h0, 10'h301, 3'h0}, "tag");
        wr(SEL_TAG, 32'h0);
        @(posedge sysClk);
        cmdAddrPending <= 1'b0;
        cmdDataPending <= 1'b1;
        waitFrames(1);
        chk("txTag slot2", 32'h0000_a000, {16'h0, txTag});
        cmdDataPending <= 1'b0;
        // requests come back one frame late, so allow two
        wr(SEL_CONTROL, 32'h8000_0000);
        waitFrames(2);
        chk("txTag high", {16'h0, 3'b100, 10'h2a5, 3'h0}, {16'h0, txTag});
        wr(SEL_POLARITY, 32'h0);
        waitFrames(2);
        chk("txTag low", {16'h0, 3'b100, 10'h15a, 3'h0}, {16'h0, txTag});
        wr(SEL_CONTROL, 32'h0);
    endtask : t_link
    task automatic t_fifo;
        int   n;
        logic acc;
        n = 0;
        waitFrames(1);
        repeat (40) @(posedge sysClk);
        pcmWrData <= 20'h01000;
        pcmWrValid <= 1'b1;
        repeat (40) begin
            #1;
            acc = pcmWrReady;
            @(posedge sysClk);
            if (acc) begin
                n++;
                pcmWrData <= pcmWrData + 20'h1;
            end
        end
        pcmWrValid <= 1'b0;
        chk("accepted", 32'd32, 32'(n));
        waitFrames(1);
        chk("slot3 data", 32'h0000_1000, {12'h0, txSlot3});
        chk("slot4 data", 32'h0, {12'h0, txSlot4});
        chk("pcmWrReady", 32'h1, {31'h0, pcmWrReady});
        @(posedge sysClk);
        pcmWrValid <= 1'b1;
        @(posedge sysClk);
        pcmWrValid <= 1'b0;
        #1;
        chk("pcmWrReady full", 32'h0, {31'h0, pcmWrReady});
        wr(SEL_CONTROL, 32'h0001_0000);
        repeat (2) @(posedge sysClk);
        #1;
        chk("pcmWrReady flushed", 32'h1, {31'h0, pcmWrReady});
        // with dma on, slot 4 drains the second entry of the same FIFO
        wr(SEL_CONTROL, 32'h0020_0000);
        @(posedge sysClk);
        pcmWrData <= 20'h0aaaa;
        pcmWrValid <= 1'b1;
        @(posedge sysClk);
        pcmWrData <= 20'h05555;
        @(posedge sysClk);
        pcmWrValid <= 1'b0;
        waitFrames(1);
        chk("slot3 pair", 32'h0000_aaaa, {12'h0, txSlot3});
        chk("slot4 pair", 32'h0000_5555, {12'h0, txSlot4});
        wr(SEL_CONTROL, 32'h0);
    endtask : t_fifo
    // mid-run hardware reset must clear every register
    task automatic t_reset;
        wr(SEL_POLARITY, 32'hffff_ffff);
        wr(SEL_TAG, 32'h0000_1ff8);
        wr(SEL_CONTROL, 32'h8060_0000);
        chk("enables set", 32'h7, {29'h0, version20, rxDmaEnable, txDmaEnable});
        @(posedge sysClk);
        arstN <= 1'b0;
        repeat (3) @(posedge sysClk);
        arstN <= 1'b1;
        #1;
        chk("enables reset", 32'h0, {29'h0, version20, rxDmaEnable, txDmaEnable});
        rdChk(SEL_TAG, 32'h0, "tag after reset");
        rdChk(SEL_POLARITY, 32'h0, "polarity after reset");
    endtask : t_reset
    initial begin
        {regWr, regRd, pcmWrValid, cmdAddrPending, cmdDataPending} = 5'h0;
        regSel = 2'h0;
        regWdata = 32'h0;
        pcmWrData = 20'h0;
        rxValid = 12'ha5c;
        slot_request_capture = 10'h2a5;
        nErrors = 0;
        samplesChecked = 0;
        arstN = 1'b0;
        repeat (3) @(posedge sysClk);
        arstN <= 1'b1;
        t_regs();
        t_link();
        t_fifo();
        t_reset();
        print_verdict();
    end
endmodule : tb_ac_ctrl_tag
`default_nettype wire
